// >>> crh_can_node.sv
// Protocol engine model: hands received frames in, acknowledges sends
module crh_can_node
  import crh_pkg::*;
(
  input wire logic clk, // System clock
  output logic rxValid, // Frame pulse
  output logic rxRemote, // Remote request
  output logic [ID_W-1:0] rxId, // Identifier
  output logic [3:0] rxDlc, // Length code
  output logic [63:0] rxData, // Bytes, byte 0 low
  input wire logic txValid, // Frame waiting
  output logic txDone // Frame sent pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [97:0] frameQ[$];
  int txLat = 0;
  int txCnt = 0;
  int seedN = 90341;

  // Quiet lines at time zero
  initial begin
    rxValid = 1'b0;
    rxRemote = 1'b0;
    rxId = '0;
    rxDlc = 4'h0;
    rxData = '0;
    txDone = 1'b0;
  end

  // Queue a frame; it reaches the block within three edges
  task automatic send(input logic rem, input logic [ID_W-1:0] id,
      input logic [3:0] dlc, input logic [63:0] d);
    frameQ.push_back({rem, id, dlc, d});
    repeat (3) @(posedge clk);
  endtask : send

  // Idle fields churn so a stale value is never mistaken for a frame
  always @(posedge clk) begin
    if (frameQ.size() != 0) begin
      {rxRemote, rxId, rxDlc, rxData} <= frameQ.pop_front();
      rxValid <= 1'b1;
    end else begin
      rxValid <= 1'b0;
      rxRemote <= ~rxRemote;
      rxId <= ID_W'($random(seedN));
      rxDlc <= rxDlc + 4'h1;
      rxData <= {$random(seedN), $random(seedN)};
    end
  end

  // One acknowledge per frame after txLat cycles, prompt or slow
  always @(posedge clk) begin
    txDone <= 1'b0;
    if (txValid === 1'b1 && !txDone) begin
      if (txCnt >= txLat) begin
        txDone <= 1'b1;
        txCnt <= 0;
      end else begin
        txCnt <= txCnt + 1;
      end
    end
  end
endmodule : crh_can_node

// >>> crh_data_mem.sv
// Data byte store, one 64-bit word per message center
module crh_data_mem
  import crh_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic [7:0] we, // Byte write enables
  input wire logic [3:0] waddr, // Write center
  input wire logic [63:0] wdata, // Write data
  input wire logic [3:0] raddr, // Read center
  output logic [63:0] rdata // Registered read data
);
  logic [63:0] mem [0:NUM_CTR];
  logic [63:0] rdata_r;

  // Byte-wise write, read data from a register
  always_ff @(posedge clk) begin
    for (int b = 0; b < 8; b++) begin
      if (we[b]) begin
        mem[waddr][8*b +: 8] <= wdata[8*b +: 8];
      end
    end
    rdata_r <= mem[raddr];
  end

  assign rdata = rdata_r;
endmodule : crh_data_mem

// >>> crh_msg_center.sv
// Message center bank: acceptance, remote replies and transmit pick
//
// The register offsets and register access over Avalon-MM were decided locally.
module crh_msg_center
  import crh_pkg::*;
(
  input wire logic clk, // System clock, 100 MHz
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic [ADDR_W-1:0] address, // Avalon byte address
  input wire logic read, // Avalon read
  input wire logic write, // Avalon write
  input wire logic [31:0] writedata, // Avalon write data
  input wire logic [3:0] byteenable, // Avalon byte enables
  output logic [31:0] readdata, // Avalon read data
  output logic waitrequest, // Avalon wait
  input wire logic rxValid, // Received frame, one-cycle pulse
  input wire logic rxRemote, // Frame is a remote request
  input wire logic [ID_W-1:0] rxId, // Received identifier
  input wire logic [3:0] rxDlc, // Received length code
  input wire logic [63:0] rxData, // Received bytes, byte 0 low
  output logic txValid, // Frame waiting to be sent
  output logic [3:0] txCenter, // Sending center
  output logic [ID_W-1:0] txId, // Identifier to send
  output logic [3:0] txDlc, // Length code to send
  output logic [63:0] txData, // Bytes to send, unused ones zero
  input wire logic txDone // Frame sent, one-cycle pulse
);
  logic rstMeta_r, rstN;
  logic [NUM_CTR:1] ready_r, dirTx_r, dupd_r, tih_r, txReq_r;
  logic [NUM_CTR:1] extReq_r, row_r, id_mask_enable_r, ow_r;
  logic [3:0] byteCnt_r [1:NUM_CTR];
  logic [ID_W-1:0] arbId_r [1:NUM_CTR];
  logic [ID_W-1:0] mask_r [1:NUM_CTR];
  logic [NUM_CTR:1] hit, elig, txCand, belowSel;
  logic [3:0] selIdx, txPick, lastCtr_r, txCenter_r, txDlc_r;
  logic selHit, rxAccept, selDir, selOw, selDupd, selExt, selMeme;
  logic [ID_W-1:0] selMask, selArbId, idLoad, txId_r;
  logic idWr, txStart, txDoneHit, txValid_r, softRst_r;
  crh_tx_state_t txSt_r;
  logic [63:0] txData_r, memRd, memWd;
  logic [7:0] memWe;
  logic [3:0] memWa, memRa;
  logic busPh1_r, waitrequest_r, busAccept, wrAcc, busGlobal;
  logic [31:0] readdata_r, rdVal, ctrlRd, ctrlNew, arbNew, maskNew;
  logic [3:0] busCtr, busIdx;
  logic [4:0] regOfs;

  // Byte-lane merge of a write into an old register value
  function automatic logic [31:0] beMerge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : beMerge

  // Lowest set index; 1 when empty, callers gate with an any-bit test
  function automatic logic [3:0] lowest(input logic [NUM_CTR:1] v);
    logic [3:0] r;
    r = 4'h1;
    for (int i = NUM_CTR; i >= 1; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : lowest

  // Keep only the leading bytes a length code names; codes above 8 mean 8
  function automatic logic [63:0] dlcMask(input logic [3:0] c);
    logic [63:0] m;
    m = 64'h0;
    for (int b = 0; b < 8; b++) begin
      if (4'(b) < c) begin
        m[8*b +: 8] = 8'hff;
      end
    end
    return m;
  endfunction : dlcMask

  // Reset release through two flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_r <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstN <= rstMeta_r;
    end
  end

  // Acceptance: exact or masked identifier match on ready centers
  always_comb begin
    for (int i = 1; i <= NUM_CTR; i++) begin
      hit[i] = ready_r[i] && (((rxId ^ arbId_r[i]) &
               (id_mask_enable_r[i] ? mask_r[i] : MASK_RST)) == ID_RST);
      // Without overwrite a busy receive center is skipped: next free one wins
      elig[i] = hit[i] && (ow_r[i] || !(dupd_r[i] || extReq_r[i]) ||
                (rxRemote && dirTx_r[i])) &&
                (rxRemote || !dirTx_r[i]);
      txCand[i] = txReq_r[i] && ready_r[i] && !tih_r[i] &&
                  dupd_r[i] && dirTx_r[i];
    end
  end

  // Centers below the pick; kept apart so no block feeds itself
  always_comb begin
    for (int i = 1; i <= NUM_CTR; i++) begin
      belowSel[i] = 4'(i) < selIdx;
    end
  end

  // Selected center and its fields
  assign selIdx = lowest(elig);
  assign selHit = |elig;
  assign rxAccept = rxValid && selHit;
  assign selDir = dirTx_r[selIdx];
  assign selOw = ow_r[selIdx];
  assign selDupd = dupd_r[selIdx];
  assign selExt = extReq_r[selIdx];
  assign selMeme = id_mask_enable_r[selIdx];
  assign selMask = mask_r[selIdx];
  assign selArbId = arbId_r[selIdx];
  assign idLoad = selMeme ? (rxId & selMask) : rxId;
  // Identifier only rewritten where overwrite is on; unmasked it is equal
  assign idWr = rxAccept && selOw;

  // Bus decode
  assign busCtr = address[ADDR_W-1:CTR_LSB];
  assign regOfs = address[CTR_LSB-1:0];
  assign busGlobal = busCtr == 4'h0;
  assign busIdx = busGlobal ? 4'h1 : busCtr;
  assign txDoneHit = txDone && (txSt_r == TX_SEND);
  assign txStart = (txSt_r == TX_IDLE) && (|txCand) && !softRst_r;
  assign txPick = lowest(txCand);
  // Bus waits on frame events so a write never meets a hardware update
  assign busAccept = (read || write) && waitrequest_r && !busPh1_r &&
                     !rxValid && !txDoneHit && !txStart;
  assign wrAcc = busAccept && write;

  // Register images
  always_comb begin
    ctrlRd = 32'h0;
    ctrlRd[CB_READY] = ready_r[busIdx];
    ctrlRd[CB_DIR] = dirTx_r[busIdx];
    ctrlRd[CB_DUPD] = dupd_r[busIdx];
    ctrlRd[CB_TIH] = tih_r[busIdx];
    ctrlRd[CB_TXRQ] = txReq_r[busIdx];
    ctrlRd[CB_EXRQ] = extReq_r[busIdx];
    ctrlRd[CB_ROW] = row_r[busIdx];
    ctrlRd[CB_ID_MASK_ENABLE] = id_mask_enable_r[busIdx];
    ctrlRd[CB_DLC +: 4] = byteCnt_r[busIdx];
  end
  assign ctrlNew = beMerge(ctrlRd, writedata, byteenable);
  assign arbNew = beMerge({arbId_r[busIdx], 2'b00, ow_r[busIdx]},
                          writedata, byteenable);
  assign maskNew = beMerge({mask_r[busIdx], 3'b000}, writedata, byteenable);

  // Read mux, sampled one cycle after the accept
  assign rdVal = (busGlobal && regOfs == OFS_STAT) ?
                   {27'h0, txSt_r != TX_IDLE, lastCtr_r} :
                 busGlobal ? 32'h0 :
                 (regOfs == OFS_CTRL) ? ctrlRd :
                 (regOfs == OFS_ARB) ?
                   {arbId_r[busIdx], 2'b00, ow_r[busIdx]} :
                 (regOfs == OFS_MASK) ? {mask_r[busIdx], 3'b000} :
                 (regOfs == OFS_DLO) ? memRd[31:0] :
                 (regOfs == OFS_DHI) ? memRd[63:32] : 32'h0;

  // Data store: received data frame wins the write port
  assign memWe = (rxAccept && !rxRemote) ? 8'hff :
                 (wrAcc && !busGlobal && regOfs == OFS_DLO) ?
                   {4'h0, byteenable} :
                 (wrAcc && !busGlobal && regOfs == OFS_DHI) ?
                   {byteenable, 4'h0} : 8'h00;
  assign memWa = rxAccept ? selIdx : busIdx;
  assign memWd = rxAccept ? rxData : {writedata, writedata};
  assign memRa = txStart ? txPick : busIdx;

  crh_data_mem uMem (
    .clk(clk),
    .we(memWe),
    .waddr(memWa),
    .wdata(memWd),
    .raddr(memRa),
    .rdata(memRd)
  );

  // Avalon handshake: accept, fetch, answer with waitrequest low
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      busPh1_r <= 1'b0;
      waitrequest_r <= 1'b1;
      readdata_r <= 32'h0;
      softRst_r <= 1'b0;
    end else begin
      busPh1_r <= busAccept;
      waitrequest_r <= !busPh1_r;
      readdata_r <= busPh1_r ? rdVal : readdata_r;
      softRst_r <= wrAcc && busGlobal && regOfs == OFS_STAT &&
                   byteenable[0] && writedata[GB_SRST];
    end
  end

  // Per-center flags; software writes and frame events never coincide
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      {ready_r, dirTx_r, dupd_r, tih_r, txReq_r} <= '0;
      {extReq_r, row_r, id_mask_enable_r, ow_r} <= '0;
    end else begin
      for (int i = 1; i <= NUM_CTR; i++) begin
        if (softRst_r) begin
          {ready_r[i], dirTx_r[i], dupd_r[i], tih_r[i]} <= 4'h0;
          {txReq_r[i], extReq_r[i], row_r[i]} <= 3'h0;
        end else if (wrAcc && busCtr == 4'(i)) begin
          if (regOfs == OFS_CTRL) begin
            ready_r[i] <= ctrlNew[CB_READY];
            dirTx_r[i] <= ctrlNew[CB_DIR];
            dupd_r[i] <= ctrlNew[CB_DUPD];
            tih_r[i] <= ctrlNew[CB_TIH];
            txReq_r[i] <= ctrlNew[CB_TXRQ];
            extReq_r[i] <= ctrlNew[CB_EXRQ];
            row_r[i] <= ctrlNew[CB_ROW];
            id_mask_enable_r[i] <= ctrlNew[CB_ID_MASK_ENABLE];
          end
          if (regOfs == OFS_ARB) begin
            ow_r[i] <= arbNew[ARB_OW];
          end
        end else if (rxAccept && selIdx == 4'(i)) begin
          if (dirTx_r[i]) begin
            extReq_r[i] <= 1'b1;
            txReq_r[i] <= 1'b1;
          end else begin
            // Receive side never raises the transmit request
            dupd_r[i] <= 1'b1;
            extReq_r[i] <= extReq_r[i] || rxRemote;
            row_r[i] <= row_r[i] || (ow_r[i] && dupd_r[i]);
          end
        end else if (txDoneHit && txCenter_r == 4'(i)) begin
          txReq_r[i] <= 1'b0;
          extReq_r[i] <= 1'b0;
        end
      end
    end
  end

  // Identifier, mask and byte count per center
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      for (int i = 1; i <= NUM_CTR; i++) begin
        arbId_r[i] <= ID_RST;
        mask_r[i] <= MASK_RST;
        byteCnt_r[i] <= DLC_RST;
      end
    end else begin
      for (int i = 1; i <= NUM_CTR; i++) begin
        if (wrAcc && busCtr == 4'(i)) begin
          if (regOfs == OFS_ARB) begin
            arbId_r[i] <= arbNew[31:ARB_ID];
          end
          if (regOfs == OFS_MASK) begin
            mask_r[i] <= maskNew[31:ARB_ID];
          end
          if (regOfs == OFS_CTRL) begin
            byteCnt_r[i] <= ctrlNew[CB_DLC +: 4];
          end
        end else if (rxAccept && selIdx == 4'(i)) begin
          byteCnt_r[i] <= rxDlc;
          if (idWr) begin
            arbId_r[i] <= idLoad;
          end
        end
      end
    end
  end

  // Transmit sequencer: pick, fetch data, hold until sent
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      txSt_r <= TX_IDLE;
      {txValid_r, txCenter_r, txDlc_r, txId_r, txData_r} <= '0;
      lastCtr_r <= 4'h0;
    end else begin
      lastCtr_r <= rxAccept ? selIdx : lastCtr_r;
      case (txSt_r)
        TX_IDLE: begin
          if (txStart) begin
            txCenter_r <= txPick;
            txSt_r <= TX_FETCH;
          end
        end
        TX_FETCH: begin
          txId_r <= arbId_r[txCenter_r];
          txDlc_r <= byteCnt_r[txCenter_r];
          txData_r <= memRd & dlcMask(byteCnt_r[txCenter_r]);
          txValid_r <= 1'b1;
          txSt_r <= TX_SEND;
        end
        TX_SEND: begin
          if (txDone) begin
            txValid_r <= 1'b0;
            txSt_r <= TX_IDLE;
          end
        end
        default: txSt_r <= TX_IDLE;
      endcase
      if (softRst_r) begin
        txValid_r <= 1'b0;
        txSt_r <= TX_IDLE;
      end
    end
  end

  assign readdata = readdata_r;
  assign waitrequest = waitrequest_r;
  assign txValid = txValid_r;
  assign txCenter = txCenter_r;
  assign txId = txId_r;
  assign txDlc = txDlc_r;
  assign txData = txData_r;

  property p_rx_remote_flags;
    @(posedge clk) disable iff (!rstN)
    rxAccept && rxRemote && !selDir |=>
      extReq_r[$past(selIdx)] && dupd_r[$past(selIdx)];
  endproperty
  a_rx_remote_flags: assert property (p_rx_remote_flags)
    else $error("remote request did not set pending and updated");

  property p_no_txreq_rx;
    @(posedge clk) disable iff (!rstN)
    rxAccept && !selDir && !txReq_r[selIdx] |=> !txReq_r[$past(selIdx)];
  endproperty
  a_no_txreq_rx: assert property (p_no_txreq_rx)
    else $error("transmit request raised on receive center");

  property p_dlc_copy;
    @(posedge clk) disable iff (!rstN)
    rxAccept |=> byteCnt_r[$past(selIdx)] == $past(rxDlc);
  endproperty
  a_dlc_copy: assert property (p_dlc_copy)
    else $error("byte count not copied from frame");

  // A remote request landing on the sender that cycle re-arms it: set wins
  property p_tx_clear;
    @(posedge clk) disable iff (!rstN)
    txDoneHit && !softRst_r && !(rxAccept && selIdx == txCenter_r) |=>
      !txReq_r[$past(txCenter_r)] && !extReq_r[$past(txCenter_r)] && !txValid;
  endproperty
  a_tx_clear: assert property (p_tx_clear)
    else $error("flags not cleared after send");

  property p_data_kept;
    @(posedge clk) disable iff (!rstN)
    rxAccept && rxRemote |-> memWe == 8'h00;
  endproperty
  a_data_kept: assert property (p_data_kept)
    else $error("remote request wrote data bytes");

  property p_tx_len;
    @(posedge clk) disable iff (!rstN)
    txValid |-> (txData & ~dlcMask(txDlc)) == 64'h0;
  endproperty
  a_tx_len: assert property (p_tx_len)
    else $error("bytes beyond count sent");

  property p_id_masked;
    @(posedge clk) disable iff (!rstN)
    rxAccept && rxRemote && selOw |=> arbId_r[$past(selIdx)] ==
      ($past(rxId) & ($past(selMeme) ? $past(selMask) : MASK_RST));
  endproperty
  a_id_masked: assert property (p_id_masked)
    else $error("identifier load wrong");

  property p_row_set;
    @(posedge clk) disable iff (!rstN)
    rxAccept && !selDir && selOw && selDupd |=> row_r[$past(selIdx)];
  endproperty
  a_row_set: assert property (p_row_set)
    else $error("overwrite flag not set");

  property p_no_store_busy;
    @(posedge clk) disable iff (!rstN)
    rxAccept && !selDir |-> selOw || !(selDupd || selExt);
  endproperty
  a_no_store_busy: assert property (p_no_store_busy)
    else $error("stored into busy center");

  property p_lowest;
    @(posedge clk) disable iff (!rstN)
    rxAccept |-> (elig & belowSel) == '0;
  endproperty
  a_lowest: assert property (p_lowest)
    else $error("not the lowest eligible center");

  property p_id_kept_tx;
    @(posedge clk) disable iff (!rstN)
    rxAccept && selDir && !selOw |=>
      arbId_r[$past(selIdx)] == $past(selArbId);
  endproperty
  a_id_kept_tx: assert property (p_id_kept_tx)
    else $error("transmit center identifier altered");

  property p_tx_dir_remote;
    @(posedge clk) disable iff (!rstN)
    rxAccept && selDir |=> txReq_r[$past(selIdx)] && extReq_r[$past(selIdx)];
  endproperty
  a_tx_dir_remote: assert property (p_tx_dir_remote)
    else $error("transmit center did not mark request");
endmodule : crh_msg_center

// >>> crh_pkg.sv
// Constants, register map and types for the remote-reply and overwrite logic
package crh_pkg;
  localparam int NUM_CTR = 15;
  localparam int ID_W = 29;
  // Address map: center number in bits 8:5, register in bits 4:0
  localparam int ADDR_W = 9;
  localparam int CTR_LSB = 5;
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_ARB = 5'h04;
  localparam logic [4:0] OFS_MASK = 5'h08;
  localparam logic [4:0] OFS_DLO = 5'h0c;
  localparam logic [4:0] OFS_DHI = 5'h10;
  localparam logic [4:0] OFS_STAT = 5'h00;
  // Control word fields
  localparam int CB_READY = 0;
  localparam int CB_DIR = 1;
  localparam int CB_DUPD = 2;
  localparam int CB_TIH = 3;
  localparam int CB_TXRQ = 4;
  localparam int CB_EXRQ = 5;
  localparam int CB_ROW = 6;
  localparam int CB_ID_MASK_ENABLE = 7;
  localparam int CB_DLC = 8;
  // Arbitration and mask word fields
  localparam int ARB_OW = 0;
  localparam int ARB_ID = 3;
  // Global word fields
  localparam int GB_SRST = 0;
  localparam int ST_TXBUSY = 4;
  // Reset values
  localparam logic [ID_W-1:0] ID_RST = 29'h0;
  localparam logic [ID_W-1:0] MASK_RST = 29'h1fffffff;
  localparam logic [3:0] DLC_RST = 4'h0;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_FETCH = 2'b01,
    TX_SEND = 2'b11
  } crh_tx_state_t;
endpackage : crh_pkg

// >>> tb_top.sv
// Bench for the message center bank: bus, frames in, frames out
module tb_top
  import crh_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, reset_n = 0, read = 0, write = 0, txSeen = 0;
  logic [ADDR_W-1:0] address = '0;
  logic [31:0] writedata = '0, readdata;
  logic [3:0] byteenable = 4'hf, rxDlc, txDlc, txCenter;
  logic waitrequest, rxValid, rxRemote, txValid, txDone;
  logic [ID_W-1:0] rxId, txId;
  logic [63:0] rxData, txData;
  logic [31:0] rdQ[$];
  logic [100:0] txQ[$];
  int n_errors = 0, num_checks = 0, seed = 90341;

  // 100 MHz system clock
  always #5 clk = ~clk;

  crh_msg_center i_dut (.clk(clk), .reset_n(reset_n), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .rxValid(rxValid), .rxRemote(rxRemote),
    .rxId(rxId), .rxDlc(rxDlc), .rxData(rxData), .txValid(txValid),
    .txCenter(txCenter), .txId(txId), .txDlc(txDlc), .txData(txData),
    .txDone(txDone));

  crh_can_node i_node (.clk(clk), .rxValid(rxValid), .rxRemote(rxRemote),
    .rxId(rxId), .rxDlc(rxDlc), .rxData(rxData), .txValid(txValid),
    .txDone(txDone));

  task automatic wrap_up();
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic cmpRd(input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR readdata expected %h seen %h", e, s);
    end
  endtask : cmpRd

  task automatic cmpTx(input logic [100:0] e, input logic [100:0] s);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR tx frame expected %h seen %h", e, s);
    end
  endtask : cmpTx

  // Request held until the rising edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [3:0] c,
      input logic [4:0] o, input logic [31:0] d);
    int n;
    @(posedge clk);
    address <= {c, o};
    writedata <= d;
    write <= wr;
    read <= !wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      n_errors++;
      wrap_up();
    end
    write <= 1'b0;
    read <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] c, input logic [4:0] o,
      input logic [31:0] d);
    bus(1'b1, c, o, d);
  endtask : wr

  task automatic rd(input logic [3:0] c, input logic [4:0] o,
      input logic [31:0] e);
    rdQ.push_back(e);
    bus(1'b0, c, o, 32'h0);
  endtask : rd

  // Bytes beyond the count go out as zero
  task automatic expTx(input logic [3:0] c, input logic [ID_W-1:0] id,
      input logic [3:0] n, input logic [63:0] d);
    for (int i = 0; i < 8; i++) begin
      if (i >= n) d[i*8 +: 8] = 8'h00;
    end
    txQ.push_back({c, id, n, d});
  endtask : expTx

  // Wait until the noted frame went out and the line is idle again
  task automatic waitTx();
    int n;
    n = 0;
    while ((txQ.size() != 0 || txValid !== 1'b0) && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n >= 200) begin
      n_errors++;
      wrap_up();
    end
  endtask : waitTx

  // Read data taken at the same edge that sees waitrequest low
  always @(posedge clk) begin
    if (read === 1'b1 && waitrequest === 1'b0) begin
      cmpRd(rdQ.size() != 0 ? rdQ.pop_front() : 32'hx, readdata);
    end
  end

  // Pair each sent frame with the oldest note
  always @(negedge clk) begin
    if (txValid === 1'b1 && !txSeen) begin
      cmpTx(txQ.size() != 0 ? txQ.pop_front() : 101'hx,
        {txCenter, txId, txDlc, txData});
    end
    txSeen <= txValid === 1'b1;
  end

  // Main sequence
  initial begin
    logic [63:0] d[10];
    foreach (d[i]) d[i] = {$random(seed), $random(seed)};
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset values and an unmapped place
    rd(4'h1, OFS_CTRL, 32'h0);
    rd(4'h1, OFS_MASK, 32'hfffffff8);
    wr(4'h1, 5'h14, 32'hffffffff);
    rd(4'h1, 5'h14, 32'h0);
    // Request held in a receive center, answered from another
    wr(4'h1, OFS_ARB, {29'h0a5, 3'h0});
    wr(4'h1, OFS_CTRL, 32'h01);
    i_node.send(1'b1, 29'h0a5, 4'h2, d[0]);
    rd(4'h1, OFS_CTRL, 32'h225);
    rd(4'h1, OFS_ARB, {29'h0a5, 3'h0});
    wr(4'h1, OFS_CTRL, 32'h224);
    wr(4'h2, OFS_CTRL, 32'h0a);
    wr(4'h2, OFS_ARB, {29'h0a5, 3'h0});
    wr(4'h2, OFS_DLO, d[1][31:0]);
    wr(4'h2, OFS_DHI, d[1][63:32]);
    i_node.txLat = 4;
    expTx(4'h2, 29'h0a5, 4'h2, d[1]);
    wr(4'h2, OFS_CTRL, 32'h217);
    waitTx();
    rd(4'h2, OFS_CTRL, 32'h207);
    wr(4'h1, OFS_CTRL, 32'h201);
    i_node.send(1'b0, 29'h0a5, 4'h8, d[2]);
    rd(4'h1, OFS_DLO, d[2][31:0]);
    // Transmit center answers with fewer bytes than it holds
    wr(4'h3, OFS_ARB, {29'h1b3, 3'h1});
    wr(4'h3, OFS_DLO, d[3][31:0]);
    wr(4'h3, OFS_DHI, d[3][63:32]);
    wr(4'h3, OFS_CTRL, 32'h50f);
    i_node.send(1'b1, 29'h1b3, 4'h2, d[4]);
    rd(4'h3, OFS_CTRL, 32'h23f);
    rd(4'h3, OFS_DHI, d[3][63:32]);
    i_node.txLat = 0;
    expTx(4'h3, 29'h1b3, 4'h2, d[3]);
    wr(4'h3, OFS_CTRL, 32'h237);
    waitTx();
    rd(4'h3, OFS_CTRL, 32'h207);
    // Masked acceptance with overwrite rewrites the id
    wr(4'h4, OFS_MASK, {29'h1ffffff0, 3'h0});
    wr(4'h4, OFS_ARB, {29'h2c7, 3'h1});
    wr(4'h4, OFS_CTRL, 32'h81);
    i_node.send(1'b1, 29'h2c5, 4'h3, d[4]);
    rd(4'h4, OFS_ARB, {29'h2c0, 3'h1});
    rd(4'h4, OFS_CTRL, 32'h3a5);
    // Shared ids: 5 and 6 overwrite, 7 and 8 do not
    for (int c = 5; c < 9; c++) begin
      wr(c[3:0], OFS_ARB, {(c < 7) ? 29'h3d0 : 29'h4e1, 2'h0, c < 7});
      wr(c[3:0], OFS_CTRL, 32'h01);
    end
    for (int i = 5; i < 10; i++) begin
      i_node.send(1'b0, (i < 7) ? 29'h3d0 : 29'h4e1, 4'h8, d[i]);
    end
    rd(4'h5, OFS_DLO, d[6][31:0]);
    rd(4'h5, OFS_CTRL, 32'h845);
    rd(4'h6, OFS_CTRL, 32'h01);
    rd(4'h7, OFS_DLO, d[7][31:0]);
    rd(4'h8, OFS_DHI, d[8][63:32]);
    rd(4'h8, OFS_CTRL, 32'h805);
    wr(4'h7, OFS_CTRL, 32'h801);
    i_node.send(1'b0, 29'h4e1, 4'h8, d[0]);
    rd(4'h7, OFS_DLO, d[0][31:0]);
    // Partial lanes keep the untouched bytes
    byteenable <= 4'h3;
    wr(4'h7, OFS_DHI, 32'h0);
    byteenable <= 4'hf;
    rd(4'h7, OFS_DHI, {d[0][63:48], 16'h0});
    // Guarded read of an overwrite center: a new frame shows as updated
    wr(4'h5, OFS_CTRL, 32'h801);
    rd(4'h5, OFS_DLO, d[6][31:0]);
    i_node.send(1'b0, 29'h3d0, 4'h8, d[3]);
    rd(4'h5, OFS_CTRL, 32'h805);
    wr(4'h5, OFS_CTRL, 32'h801);
    rd(4'h5, OFS_DHI, d[3][63:32]);
    rd(4'h5, OFS_CTRL, 32'h801);
    // Masked transmit center without overwrite keeps its id
    wr(4'h9, OFS_MASK, {29'h1ffffff0, 3'h0});
    wr(4'h9, OFS_ARB, {29'h5f7, 3'h0});
    wr(4'h9, OFS_CTRL, 32'h8b);
    i_node.send(1'b1, 29'h5f5, 4'h1, d[1]);
    rd(4'h9, OFS_ARB, {29'h5f7, 3'h0});
    rd(4'h9, OFS_CTRL, 32'h1bb);
    rd(4'h0, OFS_STAT, 32'h9);
    // Soft reset clears flags, keeps mask enable, count and identifier
    wr(4'h0, OFS_STAT, 32'h1);
    rd(4'h9, OFS_CTRL, 32'h180);
    rd(4'h9, OFS_ARB, {29'h5f7, 3'h0});
    wrap_up();
  end
endmodule : tb_top
